// >>> hw/intc_defines.svh
`ifndef INTC_DEFINES_SVH
`define INTC_DEFINES_SVH

// Source counts
`define NSRC          44
`define NTRAP         4
`define NCAND         48
`define SRC_MASK      48'h0FFF_FFFF_FFFF

// Register word addresses
`define A_FLAG0       6'h00
`define A_EN0         6'h04
`define A_PRIO0       6'h08
`define A_PRIO11      6'h13
`define A_EXC         6'h14
`define A_EXT         6'h15
`define A_TAKEN       6'h16
`define A_LEVEL       6'h17
`define A_MASKCNT     6'h18

// Field positions
`define NEST_BIT      15
`define ALT_BIT       15
`define MASK_BIT      14
`define TRAP_ADDR_ERR 1

// Reset values
`define LEVEL_RST     4'h0
`define REG_RST       16'h0000

// Levels and vectors
`define TRAP_LVL_TOP  4'hF
`define MASK_LVL      3'h6
`define TRAP_VEC_OFS  6'h02
`define SRC_VEC_OFS   6'h04
`define IVT_BASE      24'h000000
`define ALT_BASE      24'h000080
`define VT_LO         24'h000004
`define VT_HI         24'h0000FE

// External pin source numbers
`define SRC_EXT0      0
`define SRC_EXT1      16
`define SRC_EXT2      23
`define SRC_EXT3      36
`define SRC_EXT4      37
`define NEXT          5

`endif

// >>> hw/intc_pkg.sv
`default_nettype none
package intc_pkg;
   typedef logic [3:0] level_t;
   typedef logic [5:0] taken_vector_number_t;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h1,
      ST_OFFER  = 3'h2,
      ST_VECTOR = 3'h4
   } serve_state_e;
endpackage
`default_nettype wire

// >>> hw/arb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface arb_if #(parameter int N = 48);
   logic                  cand [N];
   intc_pkg::level_t      lvl  [N];
   logic                  win_vld;
   intc_pkg::taken_vector_number_t     win_idx;
   intc_pkg::level_t      win_lvl;
   modport ctrl (output cand, output lvl,
                 input win_vld, input win_idx, input win_lvl);
   modport arb  (input cand, input lvl,
                 output win_vld, output win_idx, output win_lvl);
endinterface
`default_nettype wire

// >>> hw/winner_select.sv
`timescale 1ns/1ps
`default_nettype none
module winner_select #(
   parameter int N = 48
) (
   input  wire logic clk,
   input  wire logic rst_n,
   arb_if.arb        a
);
   logic              b_vld;
   intc_pkg::taken_vector_number_t b_idx;
   intc_pkg::level_t  b_lvl;

   if (N < 1 || N > 64) begin : g_chk
      $error("winner_select: N must be 1..64");
   end

   // Highest level wins, lower index wins a tie
   always_comb begin
      b_vld = 1'b0;
      b_idx = '0;
      b_lvl = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (a.cand[i] && a.lvl[i] >= b_lvl) begin
            b_vld = 1'b1;
            b_idx = 6'(i);
            b_lvl = a.lvl[i];
         end
      end
   end

   // Registered winner
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a.win_vld <= 1'b0;
         a.win_idx <= '0;
         a.win_lvl <= '0;
      end else begin
         a.win_vld <= b_vld;
         a.win_idx <= b_idx;
         a.win_lvl <= b_lvl;
      end
   end
endmodule // winner_select
`default_nettype wire

// >>> hw/priority_interrupt_controller.sv
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "intc_defines.svh"
module priority_interrupt_controller (
   input  wire logic        MCLK,
   input  wire logic        RESET_N,
   input  wire logic [5:0]  REG_ADDR,
   input  wire logic [15:0] REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic      [15:0] REG_RDATA,
   input  wire logic [43:0] SRC_EVENT,
   input  wire logic [4:0]  EXT_PIN,
   input  wire logic [3:0]  TRAP_EVENT,
   output logic             INT_REQ,
   output logic      [23:0] VEC_ADDR,
   output logic      [3:0]  CPU_LEVEL,
   input  wire logic        INT_ACK,
   input  wire logic [23:0] VEC_DATA,
   input  wire logic        VEC_DATA_VALID,
   output logic             PC_LOAD,
   output logic      [23:0] PC_LOAD_ADDR,
   input  wire logic        SERV_RETURN,
   input  wire logic [3:0]  RETURN_LEVEL,
   input  wire logic        MASK_START,
   input  wire logic [13:0] MASK_COUNT,
   input  wire logic        INSTR_RETIRE,
   input  wire logic        FETCH_VALID,
   input  wire logic [23:0] FETCH_ADDR,
   input  wire logic        JUMP_VALID,
   input  wire logic [23:0] JUMP_TARGET,
   output logic             ADDR_TRAP
);
   localparam int EXT_MAP [`NEXT] = '{`SRC_EXT0, `SRC_EXT1,
      `SRC_EXT2, `SRC_EXT3, `SRC_EXT4};

   logic                    rst_meta_q;
   logic                    rst_sync_q;
   logic                    rst_n;
   logic [4:0]              pin_m_q;
   logic [4:0]              pin_s_q;
   logic [4:0]              pin_d_q;
   logic [4:0]              ext_edge;
   logic [43:0]             ext_set;
   logic [47:0]             flag_q;
   logic [47:0]             flag_d;
   logic [47:0]             en_q;
   logic [47:0]             en_d;
   logic [2:0]              prio_q [`NSRC];
   logic [15:0]             exc_q;
   logic [15:0]             ext_q;
   logic [15:0]             taken_q;
   logic [3:0]              level_q;
   logic [13:0]             mask_cnt_q;
   logic                    mask_active;
   logic                    servicing_q;
   logic                    int_req_q;
   logic [23:0]             vec_addr_q;
   logic                    pc_load_q;
   logic [23:0]             pc_addr_q;
   logic                    addr_trap_q;
   logic [15:0]             rdata_q;
   logic [15:0]             rd_mux;
   logic [15:0]             prio_rd;
   logic [5:0]              prio_idx;
   logic                    prio_sel;
   logic                    nest_block;
   logic                    addr_err;
   logic [3:0]              trap_set;
   logic [5:0]              offer_idx_q;
   logic [5:0]              win_vec;
   logic [23:0]             vec_base;
   logic                    cand_flat [`NCAND];
   intc_pkg::serve_state_e  st_q;

   arb_if #(.N(`NCAND)) arb ();

   winner_select #(.N(`NCAND)) u_winner (
      .clk   (MCLK),
      .rst_n (rst_n),
      .a     (arb.arb)
   );

   // Reset release through two flops
   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   // External pin synchroniser and edge history
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         pin_m_q <= '0;
         pin_s_q <= '0;
         pin_d_q <= '0;
      end else begin
         pin_m_q <= EXT_PIN;
         pin_s_q <= pin_m_q;
         pin_d_q <= pin_s_q;
      end
   end

   // Edge polarity per pin: 0 rising, 1 falling
   assign ext_edge = (ext_q[4:0] & pin_d_q & ~pin_s_q)
                   | (~ext_q[4:0] & ~pin_d_q & pin_s_q);

   // Pin events mapped onto their source numbers
   always_comb begin
      ext_set = '0;
      for (int k = 0; k < `NEXT; k++) begin
         ext_set[EXT_MAP[k]] = ext_edge[k];
      end
   end

   // Flag and enable words: flag set wins over software write
   always_comb begin
      flag_d = flag_q;
      en_d   = en_q;
      for (int w = 0; w < 3; w++) begin
         if (REG_WR && REG_ADDR == `A_FLAG0 + 6'(w)) begin
            flag_d[w*16 +: 16] = REG_WDATA;
         end
         if (REG_WR && REG_ADDR == `A_EN0 + 6'(w)) begin
            en_d[w*16 +: 16] = REG_WDATA;
         end
      end
      flag_d = (flag_d | {4'h0, SRC_EVENT | ext_set}) & `SRC_MASK;
      en_d   = en_d & `SRC_MASK;
   end

   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= '0;
         en_q   <= '0;
      end else begin
         flag_q <= flag_d;
         en_q   <= en_d;
      end
   end

   // Nested service blocks every source, but not the traps, while inhibit is set
   assign nest_block  = exc_q[`NEST_BIT] && servicing_q;
   assign mask_active = (mask_cnt_q != 14'h0000);

   // Per-source priority field and eligibility
   for (genvar i = 0; i < `NSRC; i++) begin : g_src
      localparam logic [5:0] RA = `A_PRIO0 + 6'(i / 4);
      always_ff @(posedge MCLK or negedge rst_n) begin
         if (!rst_n) begin
            prio_q[i] <= 3'h0;
         end else if (REG_WR && REG_ADDR == RA) begin
            prio_q[i] <= REG_WDATA[(i % 4) * 4 +: 3];
         end
      end
      assign cand_flat[`NTRAP + i] = flag_q[i] && en_q[i]
         && (prio_q[i] != 3'h0)
         && ({1'b0, prio_q[i]} > level_q)
         && !(mask_active && prio_q[i] <= `MASK_LVL)
         && !nest_block;
      assign arb.lvl[`NTRAP + i] = {1'b0, prio_q[i]};
   end

   // Traps sit above every source level
   for (genvar t = 0; t < `NTRAP; t++) begin : g_trap
      localparam logic [3:0] TL = `TRAP_LVL_TOP - 4'(t);
      assign cand_flat[t] = exc_q[t] && (TL > level_q);
      assign arb.lvl[t]   = TL;
   end

   assign arb.cand = cand_flat;

   // Vector number and table base
   assign win_vec  = (arb.win_idx < 6'(`NTRAP))
                   ? arb.win_idx + `TRAP_VEC_OFS
                   : arb.win_idx + `SRC_VEC_OFS;
   assign vec_base = ext_q[`ALT_BIT] ? `ALT_BASE : `IVT_BASE;

   // Vector space check on fetch and absolute jump
   assign addr_err = (FETCH_VALID && FETCH_ADDR >= `VT_LO
                      && FETCH_ADDR <= `VT_HI)
                   || (JUMP_VALID && JUMP_TARGET >= `VT_LO
                      && JUMP_TARGET <= `VT_HI);
   assign trap_set = TRAP_EVENT
                   | {2'b00, addr_err, 1'b0};

   // Exception and external control words
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         exc_q <= `REG_RST;
         ext_q <= `REG_RST;
      end else begin
         if (REG_WR && REG_ADDR == `A_EXC) begin
            exc_q <= {REG_WDATA[15], 11'h000,
                      REG_WDATA[3:0] | trap_set};
         end else begin
            exc_q <= {exc_q[15:4], exc_q[3:0] | trap_set};
         end
         if (REG_WR && REG_ADDR == `A_EXT) begin
            ext_q <= {REG_WDATA[15], 10'h000, REG_WDATA[4:0]};
         end
      end
   end

   // Timed mask counter, one step per retired instruction
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         mask_cnt_q <= 14'h0000;
      end else if (MASK_START) begin
         mask_cnt_q <= MASK_COUNT;
      end else if (REG_WR && REG_ADDR == `A_MASKCNT) begin
         mask_cnt_q <= REG_WDATA[13:0];
      end else if (INSTR_RETIRE && mask_active) begin
         mask_cnt_q <= mask_cnt_q - 14'h0001;
      end
   end

   // Address error trap pulse
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         addr_trap_q <= 1'b0;
      end else begin
         addr_trap_q <= addr_err;
      end
   end

   // Service sequence: offer, acknowledge, vector load
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         st_q        <= intc_pkg::ST_IDLE;
         int_req_q   <= 1'b0;
         taken_q     <= `REG_RST;
         offer_idx_q <= 6'h00;
         vec_addr_q  <= 24'h000000;
         pc_load_q   <= 1'b0;
         pc_addr_q   <= 24'h000000;
      end else begin
         pc_load_q <= 1'b0;
         case (st_q)
            intc_pkg::ST_IDLE: begin
               if (arb.win_vld && cand_flat[arb.win_idx]) begin
                  taken_q     <= {4'h0, arb.win_lvl, 2'b00,
                                  win_vec};
                  offer_idx_q <= arb.win_idx;
                  vec_addr_q  <= vec_base
                               + {17'h00000, win_vec, 1'b0};
                  int_req_q   <= 1'b1;
                  st_q        <= intc_pkg::ST_OFFER;
               end
            end
            intc_pkg::ST_OFFER: begin
               if (INT_ACK) begin
                  int_req_q <= 1'b0;
                  st_q      <= intc_pkg::ST_VECTOR;
               end else if (!cand_flat[offer_idx_q]) begin
                  int_req_q <= 1'b0;
                  st_q      <= intc_pkg::ST_IDLE;
               end
            end
            intc_pkg::ST_VECTOR: begin
               if (VEC_DATA_VALID) begin
                  pc_load_q <= 1'b1;
                  pc_addr_q <= VEC_DATA;
                  st_q      <= intc_pkg::ST_IDLE;
               end
            end
            default: begin
               int_req_q <= 1'b0;
               st_q      <= intc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // CPU level: hardware on take and return, software unless inhibited
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         level_q     <= `LEVEL_RST;
         servicing_q <= 1'b0;
      end else if (st_q == intc_pkg::ST_OFFER && INT_ACK) begin
         level_q     <= taken_q[11:8];
         servicing_q <= 1'b1;
      end else if (SERV_RETURN) begin
         level_q     <= RETURN_LEVEL;
         servicing_q <= 1'b0;
      end else if (REG_WR && REG_ADDR == `A_LEVEL
                   && !exc_q[`NEST_BIT]) begin
         level_q <= REG_WDATA[3:0];
      end
   end

   // Priority word read: nibble bit 3 stays zero
   assign prio_idx = REG_ADDR - `A_PRIO0;
   assign prio_sel = REG_ADDR >= `A_PRIO0 && REG_ADDR <= `A_PRIO11;

   always_comb begin
      int k;
      k       = 0;
      prio_rd = 16'h0000;
      for (int j = 0; j < 4; j++) begin
         k = int'(prio_idx) * 4 + j;
         if (k < `NSRC) begin
            prio_rd[j*4 +: 3] = prio_q[k];
         end
      end
   end

   // Read decode
   always_comb begin
      case (REG_ADDR)
         6'h00, 6'h01, 6'h02:
            rd_mux = flag_q[REG_ADDR[1:0]*16 +: 16];
         6'h04, 6'h05, 6'h06:
            rd_mux = en_q[REG_ADDR[1:0]*16 +: 16];
         `A_EXC:     rd_mux = exc_q;
         `A_EXT:     rd_mux = {ext_q[15], mask_active,
                               ext_q[13:0]};
         `A_TAKEN:   rd_mux = taken_q;
         `A_LEVEL:   rd_mux = {12'h000, level_q};
         `A_MASKCNT: rd_mux = {2'b00, mask_cnt_q};
         default:    rd_mux = prio_sel ? prio_rd : 16'h0000;
      endcase
   end

   // Read data stands one cycle after the strobe
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= REG_RD ? rd_mux : 16'h0000;
      end
   end

   assign REG_RDATA    = rdata_q;
   assign INT_REQ      = int_req_q;
   assign VEC_ADDR     = vec_addr_q;
   assign CPU_LEVEL    = level_q;
   assign PC_LOAD      = pc_load_q;
   assign PC_LOAD_ADDR = pc_addr_q;
   assign ADDR_TRAP    = addr_trap_q;
endmodule // priority_interrupt_controller
`default_nettype wire

// >>> bench/intc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module intc_monitor (
   input wire logic        MCLK,
   input wire logic        RESET_N,
   input wire logic        REG_WR,
   input wire logic        INT_REQ,
   input wire logic        INT_ACK,
   input wire logic [23:0] VEC_ADDR,
   input wire logic [3:0]  CPU_LEVEL,
   input wire logic [23:0] VEC_DATA,
   input wire logic        VEC_DATA_VALID,
   input wire logic        PC_LOAD,
   input wire logic [23:0] PC_LOAD_ADDR,
   input wire logic        SERV_RETURN,
   input wire logic [3:0]  RETURN_LEVEL,
   input wire logic        FETCH_VALID,
   input wire logic [23:0] FETCH_ADDR,
   input wire logic        JUMP_VALID,
   input wire logic [23:0] JUMP_TARGET,
   input wire logic        ADDR_TRAP
);
   wire logic fin;
   wire logic jin;
   // Accesses that land in vector space
   assign fin = FETCH_VALID && FETCH_ADDR >= 24'h000004
                && FETCH_ADDR <= 24'h0000FE;
   assign jin = JUMP_VALID && JUMP_TARGET >= 24'h000004
                && JUMP_TARGET <= 24'h0000FE;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   fetch_trap_a: assert property (fin |=> ADDR_TRAP)
      else $error("vector space fetch gave no trap");
   jump_trap_a: assert property (jin |=> ADDR_TRAP)
      else $error("jump into vector space gave no trap");
   no_trap_a: assert property (!fin && !jin |=> !ADDR_TRAP)
      else $error("trap without vector space access");
   pc_source_a: assert property (PC_LOAD |-> $past(VEC_DATA_VALID)
      && PC_LOAD_ADDR == $past(VEC_DATA))
      else $error("pc load not from fetched vector word");
   pc_pulse_a: assert property (PC_LOAD |=> !PC_LOAD)
      else $error("pc load longer than one cycle");
   ack_level_a: assert property (INT_REQ && INT_ACK
      |=> !INT_REQ && CPU_LEVEL != 4'h0)
      else $error("acknowledge did not take the offer");
   vec_range_a: assert property (INT_REQ |-> VEC_ADDR >= 24'h000004
      && VEC_ADDR <= 24'h0000FE)
      else $error("offered vector outside table");
   level_hold_a: assert property (!INT_ACK && !SERV_RETURN && !REG_WR
      |=> $stable(CPU_LEVEL))
      else $error("cpu level changed without cause");
   return_level_a: assert property (SERV_RETURN && !INT_ACK
      |=> CPU_LEVEL == $past(RETURN_LEVEL))
      else $error("return did not restore level");
endmodule // intc_monitor
bind priority_interrupt_controller intc_monitor intc_monitor_i (
   .MCLK(MCLK), .RESET_N(RESET_N), .REG_WR(REG_WR), .INT_REQ(INT_REQ),
   .INT_ACK(INT_ACK), .VEC_ADDR(VEC_ADDR), .CPU_LEVEL(CPU_LEVEL),
   .VEC_DATA(VEC_DATA), .VEC_DATA_VALID(VEC_DATA_VALID),
   .PC_LOAD(PC_LOAD), .PC_LOAD_ADDR(PC_LOAD_ADDR),
   .SERV_RETURN(SERV_RETURN), .RETURN_LEVEL(RETURN_LEVEL),
   .FETCH_VALID(FETCH_VALID), .FETCH_ADDR(FETCH_ADDR),
   .JUMP_VALID(JUMP_VALID), .JUMP_TARGET(JUMP_TARGET), .ADDR_TRAP(ADDR_TRAP)
);
`default_nettype wire

// >>> bench/core_model.sv
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input  wire logic        clk,
   input  wire logic        go,
   input  wire logic        slow,
   input  wire logic        int_req,
   input  wire logic [23:0] vec_addr,
   output logic             int_ack,
   output logic      [23:0] vec_data,
   output logic             vec_data_valid,
   output logic      [23:0] seen_addr
);
   logic       pend_q;
   logic [2:0] wait_q;
   initial begin
      {int_ack, vec_data_valid, pend_q, wait_q} = '0;
      vec_data = 24'h000000;
      seen_addr = 24'h000000;
   end
   // Take an offer, then hand back the vector word, promptly or late
   always @(posedge clk) begin
      int_ack <= 1'b0;
      vec_data_valid <= 1'b0;
      vec_data <= ~vec_data; // Idle bus keeps moving
      if (pend_q) begin
         if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
         end else begin
            vec_data_valid <= 1'b1;
            vec_data <= seen_addr ^ 24'hA50000;
            pend_q <= 1'b0;
         end
      end else if (go && int_req && !int_ack) begin
         int_ack <= 1'b1;
         pend_q <= 1'b1;
         seen_addr <= vec_addr;
         wait_q <= slow ? 3'h5 : 3'h0;
      end
   end
endmodule // core_model
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        MCLK, RESET_N, REG_WR, REG_RD, INT_REQ, INT_ACK, PC_LOAD;
   logic        VEC_DATA_VALID, SERV_RETURN, MASK_START, INSTR_RETIRE;
   logic        FETCH_VALID, JUMP_VALID, ADDR_TRAP, go, slow;
   logic [3:0]  CPU_LEVEL, RETURN_LEVEL, TRAP_EVENT;
   logic [4:0]  pins;
   logic [5:0]  REG_ADDR;
   logic [13:0] MASK_COUNT;
   logic [15:0] REG_WDATA, REG_RDATA;
   logic [23:0] VEC_ADDR, VEC_DATA, PC_LOAD_ADDR, FETCH_ADDR, JUMP_TARGET;
   logic [23:0] seen;
   logic [43:0] SRC_EVENT;
   int          fails, checks_done;
   priority_interrupt_controller priority_interrupt_controller_i (
      .MCLK(MCLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_RDATA(REG_RDATA), .SRC_EVENT(SRC_EVENT), .EXT_PIN(pins),
      .TRAP_EVENT(TRAP_EVENT), .INT_REQ(INT_REQ), .VEC_ADDR(VEC_ADDR),
      .CPU_LEVEL(CPU_LEVEL), .INT_ACK(INT_ACK), .VEC_DATA(VEC_DATA),
      .VEC_DATA_VALID(VEC_DATA_VALID), .PC_LOAD(PC_LOAD),
      .PC_LOAD_ADDR(PC_LOAD_ADDR), .SERV_RETURN(SERV_RETURN),
      .RETURN_LEVEL(RETURN_LEVEL), .MASK_START(MASK_START),
      .MASK_COUNT(MASK_COUNT), .INSTR_RETIRE(INSTR_RETIRE),
      .FETCH_VALID(FETCH_VALID), .FETCH_ADDR(FETCH_ADDR),
      .JUMP_VALID(JUMP_VALID), .JUMP_TARGET(JUMP_TARGET),
      .ADDR_TRAP(ADDR_TRAP));
   core_model core_model_i (
      .clk(MCLK), .go(go), .slow(slow), .int_req(INT_REQ),
      .vec_addr(VEC_ADDR), .int_ack(INT_ACK), .vec_data(VEC_DATA),
      .vec_data_valid(VEC_DATA_VALID), .seen_addr(seen));
   initial begin
      MCLK = 1'b0;
      forever #4 MCLK = ~MCLK;
   end
   task end_sim;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task chk(input logic [23:0] g, input logic [23:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge MCLK);
      REG_WR <= 1'b1;
      REG_ADDR <= a;
      REG_WDATA <= d;
      @(posedge MCLK);
      REG_WR <= 1'b0;
   endtask
   task rd(input logic [5:0] a, input logic [15:0] e);
      @(posedge MCLK);
      REG_RD <= 1'b1;
      REG_ADDR <= a;
      @(posedge MCLK);
      REG_RD <= 1'b0;
      #1 chk({8'h00, REG_RDATA}, {8'h00, e});
   endtask
   task ev(input logic [43:0] v);
      @(posedge MCLK);
      SRC_EVENT <= v;
      @(posedge MCLK);
      SRC_EVENT <= 44'h0;
   endtask
   task nreq(input int n);
      repeat (n) begin
         @(posedge MCLK);
         #1 chk({23'h0, INT_REQ}, 24'h0);
      end
   endtask
   // Let the core take one offer and judge what was latched
   task serve(input int n, input logic [3:0] l, input logic [23:0] b);
      int i;
      go <= 1'b1;
      for (i = 0; i < 40 && PC_LOAD !== 1'b1; i++) begin
         @(posedge MCLK);
         #1;
      end
      go <= 1'b0;
      chk({23'h0, PC_LOAD}, 24'h1);
      chk(seen, b + 24'(2 * (n + 8)));
      chk(PC_LOAD_ADDR, seen ^ 24'hA50000);
      chk({20'h0, CPU_LEVEL}, {20'h0, l});
      rd(6'h16, {4'h0, l, 2'h0, 6'(n + 8)});
   endtask
   task ret;
      @(posedge MCLK);
      SERV_RETURN <= 1'b1;
      @(posedge MCLK);
      SERV_RETURN <= 1'b0;
      #1 chk({20'h0, CPU_LEVEL}, 24'h0);
   endtask
   task done;
      wr(6'h00, 16'h0000);
      ret;
   endtask
   task t_regs;
      int a;
      for (a = 0; a < 26; a++) rd(6'(a), 16'h0000);
      wr(6'h08, 16'hFFFF);
      rd(6'h08, 16'h7777);
      wr(6'h08, 16'h0000);
      wr(6'h3F, 16'hFFFF);
      rd(6'h3F, 16'h0000);
      wr(6'h16, 16'hFFFF);
      rd(6'h16, 16'h0000);
      wr(6'h15, 16'h4000);
      rd(6'h15, 16'h0000);
   endtask
   task t_flag;
      ev(44'h100_0000_0020);
      rd(6'h00, 16'h0020);
      rd(6'h02, 16'h0100);
      nreq(6);
      wr(6'h00, 16'h0000);
      wr(6'h02, 16'h0000);
      rd(6'h00, 16'h0000);
      wr(6'h04, 16'h0020);
      ev(44'h20);
      nreq(6);
      wr(6'h00, 16'h0000);
   endtask
   task t_take;
      wr(6'h08, 16'h5000);
      wr(6'h04, 16'h0008);
      ev(44'h8);
      serve(3, 4'h5, 24'h0);
      done;
   endtask
   task t_tie;
      slow <= 1'b1;
      wr(6'h09, 16'h0006);
      wr(6'h08, 16'h0550);
      wr(6'h04, 16'h0016);
      ev(44'h16);
      serve(4, 4'h6, 24'h0);
      done;
      ev(44'h6);
      serve(1, 4'h5, 24'h0);
      done;
      slow <= 1'b0;
   endtask
   task t_level;
      wr(6'h17, 16'h0004);
      #1 chk({20'h0, CPU_LEVEL}, 24'h4);
      wr(6'h08, 16'h4000);
      wr(6'h04, 16'h0008);
      ev(44'h8);
      nreq(6);
      wr(6'h08, 16'h5000);
      serve(3, 4'h5, 24'h0);
      done;
   endtask
   task t_nest;
      wr(6'h14, 16'h8000);
      wr(6'h17, 16'h0003);
      #1 chk({20'h0, CPU_LEVEL}, 24'h0);
      wr(6'h04, 16'h0018);
      ev(44'h8);
      serve(3, 4'h5, 24'h0);
      ev(44'h10);
      nreq(6);
      ret;
      serve(4, 4'h6, 24'h0);
      done;
      wr(6'h14, 16'h0000);
   endtask
   task t_mask;
      wr(6'h15, 16'h8000);
      @(posedge MCLK);
      MASK_START <= 1'b1;
      MASK_COUNT <= 14'h0002;
      @(posedge MCLK);
      MASK_START <= 1'b0;
      rd(6'h15, 16'hC000);
      ev(44'h10);
      nreq(6);
      @(posedge MCLK);
      INSTR_RETIRE <= 1'b1;
      repeat (2) @(posedge MCLK);
      INSTR_RETIRE <= 1'b0;
      rd(6'h15, 16'h8000);
      serve(4, 4'h6, 24'h000080);
      done;
      wr(6'h18, 16'hFFFF);
      rd(6'h18, 16'h3FFF);
      rd(6'h15, 16'hC000);
      wr(6'h18, 16'h0000);
      wr(6'h15, 16'h0000);
   endtask
   // Pin edges through the synchroniser, one pin of each polarity
   task t_pins;
      wr(6'h15, 16'h0002);
      @(posedge MCLK);
      pins <= 5'h03;
      repeat (4) @(posedge MCLK);
      rd(6'h00, 16'h0001);
      rd(6'h01, 16'h0000);
      wr(6'h00, 16'h0000);
      @(posedge MCLK);
      pins <= 5'h00;
      repeat (4) @(posedge MCLK);
      rd(6'h00, 16'h0000);
      rd(6'h01, 16'h0001);
      wr(6'h01, 16'h0000);
      wr(6'h15, 16'h0000);
   endtask
   task probe(input logic j, input logic [23:0] a, input logic e);
      @(posedge MCLK);
      FETCH_VALID <= !j;
      JUMP_VALID <= j;
      FETCH_ADDR <= a;
      JUMP_TARGET <= a;
      @(posedge MCLK);
      FETCH_VALID <= 1'b0;
      JUMP_VALID <= 1'b0;
      #1 chk({23'h0, ADDR_TRAP}, {23'h0, e});
   endtask
   task t_fetch;
      probe(1'b0, 24'h000004, 1'b1);
      probe(1'b0, 24'h0000FE, 1'b1);
      probe(1'b0, 24'h000002, 1'b0);
      probe(1'b0, 24'h000100, 1'b0);
      probe(1'b1, 24'h000080, 1'b1);
      probe(1'b1, 24'h000102, 1'b0);
      @(posedge MCLK);
      TRAP_EVENT <= 4'h1;
      @(posedge MCLK);
      TRAP_EVENT <= 4'h0;
      rd(6'h14, 16'h0003);
      wr(6'h14, 16'h0000);
      rd(6'h14, 16'h0000);
   endtask
   // Watchdog against a hang
   initial begin
      #100000;
      fails++;
      end_sim;
   end
   // Main sequence
   initial begin
      {RESET_N, REG_WR, REG_RD, SERV_RETURN, MASK_START, INSTR_RETIRE} = '0;
      {FETCH_VALID, JUMP_VALID, go, slow, RETURN_LEVEL, TRAP_EVENT} = '0;
      {REG_ADDR, REG_WDATA, MASK_COUNT, FETCH_ADDR, JUMP_TARGET, pins} = '0;
      SRC_EVENT = 44'h0;
      repeat (3) @(posedge MCLK);
      RESET_N <= 1'b1;
      repeat (3) @(posedge MCLK);
      t_regs;
      t_flag;
      t_take;
      t_tie;
      t_level;
      t_nest;
      t_mask;
      t_fetch;
      t_pins;
      end_sim;
   end
endmodule // tb
`default_nettype wire
